/* File: pkg/tx_fifo_pkg.sv */
// Shared constants, field layouts and carrier types of the transmit FIFO control block
package tx_fifo_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int PTR_W      = 10;
   localparam int EP_W       = 4;
   localparam int MAX_EP     = 16;
   localparam int CNT_HIGH_W = 2;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_DATA      = 8'h00;
   localparam logic [7:0] OFS_CNT_LOW   = 8'h01;
   localparam logic [7:0] OFS_CNT_HIGH  = 8'h02;
   localparam logic [7:0] OFS_CTRL      = 8'h03;
   localparam logic [7:0] OFS_FLAG      = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h06;
   localparam logic [7:0] OFS_EPSEL     = 8'h07;
   localparam logic [7:0] OFS_FEATURE   = 8'h08;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_FLUSH    = 7;
   localparam int CTRL_SIZE_HI  = 6;
   localparam int CTRL_SIZE_LO  = 5;
   localparam int CTRL_RSVD     = 4;
   localparam int CTRL_ISO      = 3;
   localparam int CTRL_ATM      = 2;
   localparam int CTRL_ADV      = 1;
   localparam int CTRL_REW      = 0;
   localparam int FLAG_PRES_HI  = 7;
   localparam int FLAG_PRES_LO  = 6;
   localparam int FLAG_EMPTY    = 3;
   localparam int FLAG_FULL     = 2;
   localparam int FLAG_OVER     = 0;
   localparam int STAT_TOGGLE   = 7;
   localparam int STAT_FLUSHED  = 3;
   localparam int STAT_VOID     = 2;
   localparam int STAT_ERR      = 1;
   localparam int STAT_ACK      = 0;
   localparam int FEAT_ENABLE   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h04;

   // -----------------------------------------------------------------
   // Size masks (size minus one) and presence codes
   // -----------------------------------------------------------------
   localparam logic [PTR_W-1:0] MASK_8    = 10'h007;
   localparam logic [PTR_W-1:0] MASK_16   = 10'h00F;
   localparam logic [PTR_W-1:0] MASK_32   = 10'h01F;
   localparam logic [PTR_W-1:0] MASK_64   = 10'h03F;
   localparam logic [PTR_W-1:0] MASK_256  = 10'h0FF;
   localparam logic [PTR_W-1:0] MASK_512  = 10'h1FF;
   localparam logic [PTR_W-1:0] MASK_1024 = 10'h3FF;
   localparam logic [1:0] SZ_A = 2'h0;
   localparam logic [1:0] SZ_B = 2'h1;
   localparam logic [1:0] SZ_C = 2'h2;
   localparam logic [1:0] PRES_NONE = 2'h0;
   localparam logic [1:0] PRES_SET0 = 2'h1;
   localparam logic [1:0] PRES_SET1 = 2'h2;
   localparam logic [1:0] PRES_BOTH = 2'h3;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic [EP_W-1:0] ep;
      logic            byte_read;
      logic            ack;
      logic            nak;
      logic            error;
   } sie_req_s;

   typedef struct packed {
      logic             handshake_expected;
      logic             empty;
      logic [PTR_W-1:0] read_ptr;
   } sie_view_s;

   typedef struct packed {
      logic             en;
      logic [EP_W-1:0]  ep;
      logic [PTR_W-1:0] addr;
      logic [7:0]       data;
   } fifo_wr_s;

   typedef struct packed {
      logic                  flush;
      logic [1:0]            size;
      logic                  iso;
      logic                  auto_transmit_management;
      logic                  adv;
      logic                  rew;
      logic [PTR_W-1:0]      rd_ptr;
      logic [PTR_W-1:0]      wr_ptr;
      logic [PTR_W-1:0]      rd_mark;
      logic [PTR_W-1:0]      wr_mark;
      logic [7:0]            cnt_low;
      logic [CNT_HIGH_W-1:0] cnt_high;
      logic [1:0]            presence;
      logic                  overflow;
      logic                  flushed;
      logic                  void_st;
      logic                  err;
      logic                  ack;
      logic                  toggle;
   } ep_s;

   localparam ep_s EP_RESET = '{auto_transmit_management: CTRL_RESET[CTRL_ATM], default: '0};

endpackage

/* File: src/tx_presence_update.sv */
// Data-set presence flags: validate on count write, discard on marker advance
`timescale 1ns/100ps
module tx_presence_update
   import tx_fifo_pkg::*;
(
   input  wire logic [1:0] flags,
   input  wire logic       validate,
   input  wire logic       discard,
   output logic      [1:0] next_flags,
   output logic            overflow_set
);
   always_comb begin
      next_flags   = flags;
      overflow_set = 1'b0;
      // Discard is applied first so a same-cycle validate sees the freed slot
      if (discard) begin
         next_flags = (flags == PRES_BOTH) ? PRES_SET1 : PRES_NONE;
      end
      if (validate) begin
         case (next_flags)
            PRES_NONE: next_flags = PRES_SET0;
            PRES_BOTH: overflow_set = 1'b1;
            default:   next_flags = PRES_BOTH;
         endcase
      end
   end
endmodule

/* File: src/tx_size_decode.sv */
// Transmit FIFO size decode: size select to pointer wrap mask
`timescale 1ns/100ps
module tx_size_decode
   import tx_fifo_pkg::*;
(
   input  wire logic [1:0]       size_select,
   input  wire logic             iso,
   input  wire logic             feat,
   output logic      [PTR_W-1:0] mask
);
   always_comb begin
      if (iso) begin
         case (size_select)
            SZ_A:    mask = MASK_64;
            SZ_B:    mask = MASK_256;
            SZ_C:    mask = MASK_512;
            default: mask = MASK_1024;
         endcase
      end else begin
         case (size_select)
            SZ_A:    mask = MASK_16;
            SZ_B:    mask = MASK_64;
            SZ_C:    mask = feat ? MASK_8 : MASK_64;
            default: mask = feat ? MASK_32 : MASK_64;
         endcase
      end
   end
endmodule

/* File: src/usb_tx_fifo_control.sv */
// Endpoint-indexed transmit FIFO control: registers, pointers, markers and SIE outcomes
`timescale 1ns/100ps
// What this block does
// - Flush empties FIFO, pointers, markers, byte counts
// - Flush clears status bits, sets empty flag
// - Flush bit self-clears; data toggle kept
// - Nonisochronous sizes 16, 64, 8, 32
// - Isochronous sizes 64, 256, 512, 1024
// - Feature off: nonisochronous codes 10, 11 give 64
// - Control bit 4 reads zero always
// - Isochronous flag tells engine no handshake
// - Auto ACK advances marker, keeps pointer
// - Auto NAK rewinds pointer, keeps marker
// - Auto bit resets one, gates manual, firmware-only
// - Advance moves marker to pointer, self-clears
// - Advance only with rewind, auto, flush clear
// - Rewind moves pointer to marker, self-clears
// - Rewind only with advance, auto, flush clear
// - Control accesses hit the selected endpoint only
// - Control register resets to 04H
// - Low count write validates the data set
module usb_tx_fifo_control
   import tx_fifo_pkg::*;
#(
   parameter int NUM_EP = MAX_EP
)(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire reg_req_s  req,
   output logic [7:0]     reg_rdata,
   input  wire sie_req_s  sie,
   output sie_view_s      sie_view,
   output fifo_wr_s       fifo_wr
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      ep_s [NUM_EP-1:0] ep;
      logic [EP_W-1:0]  epsel;
      logic             feat;
      logic [7:0]       rdata;
      sie_view_s        view;
      fifo_wr_s         wr;
   } state_s;

   localparam state_s STATE_RESET = '{ep: {NUM_EP{EP_RESET}}, default: '0};

   state_s s;
   state_s next_s;

   logic [NUM_EP-1:0][PTR_W-1:0] mask;
   logic [NUM_EP-1:0][1:0]       pres_next;
   logic [NUM_EP-1:0]            ovf_set;
   logic [NUM_EP-1:0]            sel_e;
   logic [NUM_EP-1:0]            sie_e;
   logic [NUM_EP-1:0]            ctrl_wr_e;
   logic [NUM_EP-1:0]            manual_adv;
   logic [NUM_EP-1:0]            manual_rew;
   logic [NUM_EP-1:0]            validate_e;
   logic [NUM_EP-1:0]            discard_e;

   if (NUM_EP < 1 || NUM_EP > MAX_EP) begin : g_check
      $error("NUM_EP must lie between 1 and the endpoint selector range");
   end

   // ------------------------------------------------------------------
   // Per-endpoint decode
   // ------------------------------------------------------------------
   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      assign sel_e[e]      = s.epsel == EP_W'(e);
      assign sie_e[e]      = sie.ep == EP_W'(e);
      assign ctrl_wr_e[e]  = req.wr && req.addr == OFS_CTRL && sel_e[e];
      assign manual_adv[e] = s.ep[e].adv && !s.ep[e].rew
                             && !s.ep[e].auto_transmit_management && !s.ep[e].flush;
      assign manual_rew[e] = s.ep[e].rew && !s.ep[e].adv
                             && !s.ep[e].auto_transmit_management && !s.ep[e].flush;
      assign validate_e[e] = req.wr && req.addr == OFS_CNT_LOW && sel_e[e]
                             && !s.ep[e].flush;
      assign discard_e[e]  = manual_adv[e]
                             || (sie_e[e] && sie.ack && s.ep[e].auto_transmit_management && !s.ep[e].flush);

      tx_size_decode u_size (
         .size_select (s.ep[e].size),
         .iso         (s.ep[e].iso),
         .feat        (s.feat),
         .mask        (mask[e])
      );

      tx_presence_update u_pres (
         .flags        (s.ep[e].presence),
         .validate     (validate_e[e]),
         .discard      (discard_e[e]),
         .next_flags   (pres_next[e]),
         .overflow_set (ovf_set[e])
      );
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s       = s;
      next_s.rdata = '0;
      next_s.wr.en = 1'b0;

      for (int e = 0; e < NUM_EP; e++) begin
         if (s.ep[e].flush) begin
            next_s.ep[e]        = EP_RESET;
            next_s.ep[e].size   = s.ep[e].size;
            next_s.ep[e].iso    = s.ep[e].iso;
            next_s.ep[e].auto_transmit_management    = s.ep[e].auto_transmit_management;
            next_s.ep[e].toggle = s.ep[e].toggle;
         end else begin
            if (manual_adv[e]) begin
               next_s.ep[e].rd_mark = s.ep[e].rd_ptr;
               next_s.ep[e].adv     = 1'b0;
            end
            if (manual_rew[e]) begin
               next_s.ep[e].rd_ptr = s.ep[e].rd_mark;
               next_s.ep[e].rew    = 1'b0;
            end
            if (sie_e[e]) begin
               if (sie.byte_read) begin
                  next_s.ep[e].rd_ptr = (s.ep[e].rd_ptr + 1'b1) & mask[e];
               end
               if (sie.ack) begin
                  next_s.ep[e].ack    = 1'b1;
                  next_s.ep[e].err    = 1'b0;
                  next_s.ep[e].toggle = !s.ep[e].toggle;
                  if (s.ep[e].auto_transmit_management) begin
                     next_s.ep[e].rd_mark = s.ep[e].rd_ptr;
                  end
               end
               if (sie.nak && s.ep[e].auto_transmit_management) begin
                  next_s.ep[e].rd_ptr = s.ep[e].rd_mark;
               end
               if (sie.error) begin
                  next_s.ep[e].err = 1'b1;
                  next_s.ep[e].ack = 1'b0;
               end
            end
            next_s.ep[e].presence = pres_next[e];
            next_s.ep[e].overflow = s.ep[e].overflow | ovf_set[e];
         end
      end

      // Firmware writes land after the hardware clears, so a set wins
      if (req.wr) begin
         if (req.addr == OFS_DATA) begin
            if (!s.ep[s.epsel].flush) begin
               next_s.wr.en              = 1'b1;
               next_s.wr.ep              = s.epsel;
               next_s.wr.addr            = s.ep[s.epsel].wr_ptr;
               next_s.wr.data            = req.wdata;
               next_s.ep[s.epsel].wr_ptr = (s.ep[s.epsel].wr_ptr + 1'b1) & mask[s.epsel];
            end
         end else if (req.addr == OFS_CNT_HIGH) begin
            next_s.ep[s.epsel].cnt_high = req.wdata[CNT_HIGH_W-1:0];
         end else if (req.addr == OFS_CNT_LOW) begin
            next_s.ep[s.epsel].cnt_low = req.wdata;
            next_s.ep[s.epsel].wr_mark = s.ep[s.epsel].wr_ptr;
         end else if (req.addr == OFS_CTRL) begin
            next_s.ep[s.epsel].flush = req.wdata[CTRL_FLUSH];
            next_s.ep[s.epsel].size  = req.wdata[CTRL_SIZE_HI:CTRL_SIZE_LO];
            next_s.ep[s.epsel].iso   = req.wdata[CTRL_ISO];
            next_s.ep[s.epsel].auto_transmit_management   = req.wdata[CTRL_ATM];
            next_s.ep[s.epsel].adv   = req.wdata[CTRL_ADV];
            next_s.ep[s.epsel].rew   = req.wdata[CTRL_REW];
         end else if (req.addr == OFS_FLAG) begin
            // Overflow is cleared by writing zero; a new overflow still wins
            next_s.ep[s.epsel].overflow = (next_s.ep[s.epsel].overflow
                                           & req.wdata[FLAG_OVER]) | ovf_set[s.epsel];
         end else if (req.addr == OFS_EPSEL) begin
            if (int'(req.wdata[EP_W-1:0]) < NUM_EP) begin
               next_s.epsel = req.wdata[EP_W-1:0];
            end
         end else if (req.addr == OFS_FEATURE) begin
            next_s.feat = req.wdata[FEAT_ENABLE];
         end
      end

      if (req.rd) begin
         if (req.addr == OFS_CNT_LOW) begin
            next_s.rdata = s.ep[s.epsel].cnt_low;
         end else if (req.addr == OFS_CNT_HIGH) begin
            next_s.rdata[CNT_HIGH_W-1:0] = s.ep[s.epsel].cnt_high;
         end else if (req.addr == OFS_CTRL) begin
            next_s.rdata[CTRL_FLUSH]               = s.ep[s.epsel].flush;
            next_s.rdata[CTRL_SIZE_HI:CTRL_SIZE_LO] = s.ep[s.epsel].size;
            next_s.rdata[CTRL_RSVD]                = 1'b0;
            next_s.rdata[CTRL_ISO]                 = s.ep[s.epsel].iso;
            next_s.rdata[CTRL_ATM]                 = s.ep[s.epsel].auto_transmit_management;
            next_s.rdata[CTRL_ADV]                 = s.ep[s.epsel].adv;
            next_s.rdata[CTRL_REW]                 = s.ep[s.epsel].rew;
         end else if (req.addr == OFS_FLAG) begin
            next_s.rdata[FLAG_PRES_HI:FLAG_PRES_LO] = s.ep[s.epsel].presence;
            next_s.rdata[FLAG_EMPTY] = s.ep[s.epsel].presence == PRES_NONE;
            next_s.rdata[FLAG_FULL]  = s.ep[s.epsel].presence == PRES_BOTH;
            next_s.rdata[FLAG_OVER]  = s.ep[s.epsel].overflow;
         end else if (req.addr == OFS_STATUS) begin
            next_s.rdata[STAT_TOGGLE]  = s.ep[s.epsel].toggle;
            next_s.rdata[STAT_FLUSHED] = s.ep[s.epsel].flushed;
            next_s.rdata[STAT_VOID]    = s.ep[s.epsel].void_st;
            next_s.rdata[STAT_ERR]     = s.ep[s.epsel].err;
            next_s.rdata[STAT_ACK]     = s.ep[s.epsel].ack;
         end else if (req.addr == OFS_EPSEL) begin
            next_s.rdata[EP_W-1:0] = s.epsel;
         end else if (req.addr == OFS_FEATURE) begin
            next_s.rdata[FEAT_ENABLE] = s.feat;
         end
      end

      // Out-of-range engine endpoints see a quiet, empty FIFO
      next_s.view = '{handshake_expected: 1'b0, empty: 1'b1, read_ptr: '0};
      if (int'(sie.ep) < NUM_EP) begin
         next_s.view.handshake_expected = !s.ep[sie.ep].iso;
         next_s.view.empty              = s.ep[sie.ep].presence == PRES_NONE;
         next_s.view.read_ptr           = s.ep[sie.ep].rd_ptr;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign sie_view  = s.view;
   assign fifo_wr   = s.wr;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ctrl_read;
      req.rd && req.addr == OFS_CTRL;
   endsequence

   property p_reserved_zero;
      s_ctrl_read |=> reg_rdata[CTRL_RSVD] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

   property p_handshake;
      int'(sie.ep) < NUM_EP |=> sie_view.handshake_expected == !$past(s.ep[sie.ep].iso);
   endproperty
   a_handshake: assert property (p_handshake) else $error("handshake flag wrong");

   for (genvar e = 0; e < NUM_EP; e++) begin : g_chk
      sequence s_flush_seen;
         s.ep[e].flush && !ctrl_wr_e[e];
      endsequence

      property p_flush_clears;
         s_flush_seen |=> s.ep[e].rd_ptr == '0 && s.ep[e].wr_ptr == '0
            && s.ep[e].rd_mark == '0 && s.ep[e].cnt_low == '0 && s.ep[e].cnt_high == '0;
      endproperty
      a_flush_clears: assert property (p_flush_clears) else $error("flush left state");

      property p_flush_status;
         s_flush_seen |=> !s.ep[e].ack && !s.ep[e].err && !s.ep[e].void_st
            && !s.ep[e].flushed && s.ep[e].presence == PRES_NONE && !s.ep[e].overflow;
      endproperty
      a_flush_status: assert property (p_flush_status) else $error("flush left flags");

      property p_flush_done;
         s_flush_seen |=> !s.ep[e].flush && s.ep[e].toggle == $past(s.ep[e].toggle);
      endproperty
      a_flush_done: assert property (p_flush_done) else $error("flush not finished");

      property p_ack_auto;
         sie_e[e] && sie.ack && !sie.nak && !sie.byte_read && s.ep[e].auto_transmit_management && !s.ep[e].flush
            |=> s.ep[e].rd_mark == $past(s.ep[e].rd_ptr) && $stable(s.ep[e].rd_ptr);
      endproperty
      a_ack_auto: assert property (p_ack_auto) else $error("ACK did not advance marker");

      property p_nak_auto;
         sie_e[e] && sie.nak && !sie.ack && s.ep[e].auto_transmit_management && !s.ep[e].flush
            |=> s.ep[e].rd_ptr == $past(s.ep[e].rd_mark) && $stable(s.ep[e].rd_mark);
      endproperty
      a_nak_auto: assert property (p_nak_auto) else $error("NAK did not rewind");

      property p_atm_fw_only;
         $changed(s.ep[e].auto_transmit_management) |-> $past(ctrl_wr_e[e]);
      endproperty
      a_atm_fw_only: assert property (p_atm_fw_only) else $error("auto bit moved alone");

      property p_advance;
         manual_adv[e] && !ctrl_wr_e[e]
            |=> !s.ep[e].adv && s.ep[e].rd_mark == $past(s.ep[e].rd_ptr);
      endproperty
      a_advance: assert property (p_advance) else $error("advance failed");

      property p_advance_blocked;
         s.ep[e].adv && s.ep[e].rew && !s.ep[e].auto_transmit_management && !s.ep[e].flush |=> $stable(s.ep[e].rd_mark);
      endproperty
      a_advance_blocked: assert property (p_advance_blocked) else $error("advance not gated");

      property p_rewind;
         manual_rew[e] && !ctrl_wr_e[e] && !(sie_e[e] && sie.byte_read)
            |=> !s.ep[e].rew && s.ep[e].rd_ptr == $past(s.ep[e].rd_mark);
      endproperty
      a_rewind: assert property (p_rewind) else $error("rewind failed");

      property p_rewind_blocked;
         s.ep[e].rew && (s.ep[e].adv || s.ep[e].auto_transmit_management) && !s.ep[e].flush
            && !(sie_e[e] && (sie.byte_read || sie.nak)) |=> $stable(s.ep[e].rd_ptr);
      endproperty
      a_rewind_blocked: assert property (p_rewind_blocked) else $error("rewind not gated");

      property p_select_only;
         req.wr && req.addr == OFS_CTRL && !sel_e[e] && !s.ep[e].flush
            |=> $stable(s.ep[e].size) && $stable(s.ep[e].iso) && $stable(s.ep[e].auto_transmit_management);
      endproperty
      a_select_only: assert property (p_select_only) else $error("write hit other endpoint");

      property p_reset_value;
         disable iff (1'b0) !rst_n |=> s.ep[e].auto_transmit_management && !s.ep[e].flush && !s.ep[e].adv
            && !s.ep[e].rew && !s.ep[e].iso && s.ep[e].size == SZ_A;
      endproperty
      a_reset_value: assert property (p_reset_value) else $error("control reset wrong");

      property p_validate;
         validate_e[e] && !discard_e[e] && s.ep[e].presence == PRES_NONE
            |=> s.ep[e].presence == PRES_SET0;
      endproperty
      a_validate: assert property (p_validate) else $error("count write not validated");
   end

endmodule

/* File: tb/sie_model.sv */
// Serial interface engine model: byte reads and handshake outcomes
`timescale 1ns/100ps
module sie_model
   import tx_fifo_pkg::*;
(
   input  wire logic clk,
   output sie_req_s  sie
);
   initial sie = '0;

   // Kind bits: 4 byte read, 2 ACK, 1 NAK; a quiet cycle follows every strobe
   // so no two strobes fall in adjacent cycles
   task automatic go(input logic [3:0] ep, input logic [2:0] k, input int n);
      repeat (n) begin
         @(posedge clk) sie <= '{ep, k[2], k[1], k[0], 1'b0};
         @(posedge clk) sie <= '{ep, 1'b0, 1'b0, 1'b0, 1'b0};
      end
   endtask

   // One transmit error outcome, followed by a quiet cycle
   task automatic fail(input logic [3:0] ep);
      @(posedge clk) sie <= '{ep, 1'b0, 1'b0, 1'b0, 1'b1};
      @(posedge clk) sie <= '{ep, 1'b0, 1'b0, 1'b0, 1'b0};
   endtask
endmodule

/* File: tb/test_usb_tx_fifo_control.sv */
// Self-checking bench of the transmit FIFO control block
`timescale 1ns/100ps
module test_usb_tx_fifo_control
   import tx_fifo_pkg::*;
;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   logic       clk       = 1'b0;
   logic       rst_n     = 1'b0;
   reg_req_s   req       = '0;
   logic [7:0] reg_rdata;
   sie_req_s   sie;
   sie_view_s  sie_view;
   fifo_wr_s   fifo_wr;
   int         error_cnt = 0;
   int         n_tests   = 0;
   int         sz [10]   = '{16, 64, 64, 64, 8, 32, 64, 256, 512, 1024};
   logic [7:0] cv [10]   = '{8'h04, 8'h24, 8'h44, 8'h64, 8'h44, 8'h64,
                             8'h0C, 8'h2C, 8'h4C, 8'h6C};

   usb_tx_fifo_control #(.NUM_EP(MAX_EP)) dut (.clk(clk), .rst_n(rst_n), .req(req),
      .reg_rdata(reg_rdata), .sie(sie), .sie_view(sie_view), .fifo_wr(fifo_wr));
   sie_model m (.clk(clk), .sie(sie));

   initial forever #50 clk = ~clk;

   task automatic check(input string nm, input logic [9:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) req <= '{a, d, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b0};
      #1 check("reg_rdata", {2'h0, reg_rdata}, {2'h0, exp});
   endtask
   // The view is registered, so the pointer shows two edges after the strobe
   task automatic ptr_is(input logic [9:0] exp);
      repeat (2) @(posedge clk);
      #1 check("read_ptr", sie_view.read_ptr, exp);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      results();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFS_CTRL, 8'h04);
      wr(OFS_CTRL, 8'h14);
      rd(OFS_CTRL, 8'h04);
      rd(8'h05, 8'h00);
      $display("reset test done");
      // Each size is flushed first, while the engine is idle
      for (int i = 0; i < 10; i++) begin
         wr(OFS_FEATURE, {7'h00, i == 4 || i == 5});
         wr(OFS_CTRL, cv[i] | 8'h80);
         m.go(4'h0, 3'h4, sz[i] - 1);
         ptr_is(10'(sz[i] - 1));
         m.go(4'h0, 3'h4, 1);
         ptr_is(10'h000);
      end
      $display("size test done");
      wr(OFS_CTRL, 8'h84);
      m.go(4'h0, 3'h4, 3);
      m.go(4'h0, 3'h2, 1);
      ptr_is(10'h003);
      m.go(4'h0, 3'h4, 2);
      m.go(4'h0, 3'h1, 1);
      ptr_is(10'h003);
      $display("auto test done");
      wr(OFS_DATA, 8'hA5);
      #1 check("wr_en", fifo_wr.en, 1'b1);
      check("wr_data", fifo_wr.data, 8'hA5);
      check("wr_addr", fifo_wr.addr, 10'h000);
      wr(OFS_DATA, 8'h5A);
      #1 check("wr_addr", fifo_wr.addr, 10'h001);
      wr(OFS_CNT_HIGH, 8'h00);
      wr(OFS_CNT_LOW, 8'h03);
      rd(OFS_FLAG, 8'h40);
      check("empty", sie_view.empty, 1'b0);
      wr(OFS_CNT_LOW, 8'h03);
      rd(OFS_FLAG, 8'hC4);
      wr(OFS_CNT_LOW, 8'h03);
      rd(OFS_FLAG, 8'hC5);
      rd(OFS_STATUS, 8'h81);
      m.fail(4'h0);
      rd(OFS_STATUS, 8'h82);
      wr(OFS_CTRL, 8'h84);
      rd(OFS_CTRL, 8'h04);
      rd(OFS_FLAG, 8'h08);
      check("empty", sie_view.empty, 1'b1);
      rd(OFS_STATUS, 8'h80);
      ptr_is(10'h000);
      wr(OFS_DATA, 8'h3C);
      #1 check("wr_addr", fifo_wr.addr, 10'h000);
      $display("flush test done");
      wr(OFS_EPSEL, 8'h01);
      wr(OFS_CTRL, 8'h0C);
      rd(OFS_CTRL, 8'h0C);
      wr(OFS_EPSEL, 8'h00);
      rd(OFS_CTRL, 8'h04);
      m.go(4'h1, 3'h0, 1);
      #1 check("handshake", sie_view.handshake_expected, 1'b0);
      m.go(4'h0, 3'h0, 1);
      #1 check("handshake", sie_view.handshake_expected, 1'b1);
      $display("endpoint test done");
      wr(OFS_CTRL, 8'h80);
      m.go(4'h0, 3'h4, 2);
      wr(OFS_CTRL, 8'h02);
      rd(OFS_CTRL, 8'h00);
      m.go(4'h0, 3'h4, 3);
      wr(OFS_CTRL, 8'h01);
      ptr_is(10'h002);
      rd(OFS_CTRL, 8'h00);
      m.go(4'h0, 3'h4, 1);
      wr(OFS_CTRL, 8'h03);
      ptr_is(10'h003);
      rd(OFS_CTRL, 8'h03);
      wr(OFS_CTRL, 8'h05);
      ptr_is(10'h003);
      $display("manual test done");
      results();
   end
endmodule
